// file: inc/blp_defines.svh
`ifndef BLP_DEFINES_SVH
`define BLP_DEFINES_SVH

// ---------------------------------------------------------------
// Clock and link-setup timing
// ---------------------------------------------------------------
`define BLP_CLK_HZ 50000000
`define BLP_UART_BPS 9600
`define BLP_UART_DIV 16'(`BLP_CLK_HZ / `BLP_UART_BPS)
`define BLP_SYNC_WAIT 2'h3
`define BLP_ZERO_COUNT 2'h3

// ---------------------------------------------------------------
// Handshake byte values
// ---------------------------------------------------------------
`define BLP_ACK_BYTE 8'h00
`define BLP_GENERIC_CODE 8'h55
`define BLP_BOOT_CODE 8'hc6
`define BLP_DEBUG_MAGIC 8'ha5

// ---------------------------------------------------------------
// Packet framing, status and reply layout
// ---------------------------------------------------------------
`define BLP_CMD_START 8'h01
`define BLP_REPLY_START 8'h81
`define BLP_PACKET_END 8'h03
`define BLP_RESP_ERROR 8'h80
`define BLP_STS_OK 8'h00
`define BLP_STS_UNSUPPORTED 8'hc0
`define BLP_STS_PACKET 8'hc1
`define BLP_STS_CHECKSUM 8'hc2
`define BLP_LEN_MIN 16'h0001
`define BLP_LEN_MAX 16'h0100
`define BLP_REPLY_LEN 8'h02
`define BLP_REPLY_LAST 3'h6
`define BLP_INQUIRY_CODE 8'h00

`endif

// file: inc/blp_pkg.sv
`default_nettype none

package blp_pkg;

  // Selected host link
  typedef enum logic [1:0] {blp_link_none, blp_link_uart, blp_link_usb, blp_link_dbg} blp_link_t;

  // Link-setup and packet-parsing states
  typedef enum logic [3:0] {
    blp_st_init, blp_st_decide, blp_st_halt, blp_st_zeros, blp_st_ack, blp_st_wait_gen,
    blp_st_boot, blp_st_drain, blp_st_hunt, blp_st_len_hi, blp_st_len_lo, blp_st_code,
    blp_st_info, blp_st_sum, blp_st_end, blp_st_reply
  } blp_state_t;

  // One received byte with its strobe
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } blp_byte_t;

  // Accepted command handed to the executor
  typedef struct packed {
    logic valid;
    logic [7:0] code;
    logic [15:0] length;
  } blp_cmd_t;

endpackage

`default_nettype wire

// file: rtl/blp_parser.sv
`timescale 1ns/1ns
`default_nettype none
`include "blp_defines.svh"

module blp_parser
  import blp_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic boot_mode_pin,
  input wire logic [7:0] debug_boot_mode_reg,
  input wire logic flash_head_erased,
  input wire logic usb_configured,
  input wire blp_byte_t uart_rx,
  input wire blp_byte_t usb_rx,
  input wire blp_byte_t dbg_rx,
  input wire logic tx_ready,
  input wire logic tx_idle,
  output logic sw_reset_req,
  output logic uart_tx_pullup_en,
  output logic uart_tx_drive_high,
  output logic [15:0] uart_baud_div,
  output logic usb_enum_en,
  output logic usb_rx_en,
  output blp_link_t link_sel,
  output logic link_up,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output blp_cmd_t cmd_out,
  output logic [7:0] err_status,
  output logic err_pulse
);

  // ---------------------------------------------------------------
  // Decoding helpers
  // ---------------------------------------------------------------
  // Defined command codes of the boot protocol
  function automatic logic cmd_defined(input logic [7:0] code);
    unique case (code)
      8'h71, 8'h2c, 8'h72, 8'h73, 8'h75, 8'h30, 8'h28, 8'h2a, 8'h29, 8'h2b, 8'h50, 8'h4e, 8'h4f,
      8'h51, 8'h52, 8'h4a, 8'h4b, 8'h4c, 8'h4d, 8'h00, 8'h3a, 8'h3b, 8'h34, 8'h12, 8'h13, 8'h15,
      8'h18, 8'h2e, 8'h26, 8'h27, 8'h36, 8'h1a: cmd_defined = 1'b1;
      default: cmd_defined = 1'b0;
    endcase
  endfunction

  // Per-command length; only the inquiry is checked, and it must carry no information bytes
  function automatic logic cmd_len_ok(input logic [7:0] code, input logic [15:0] len);
    cmd_len_ok = (code != `BLP_INQUIRY_CODE) || (len == `BLP_LEN_MIN);
  endfunction

  // Error reply byte by position: start, length, response, status, sum, end
  function automatic logic [7:0] reply_byte(input logic [2:0] idx, input logic [7:0] resp,
                                            input logic [7:0] sts);
    unique case (idx)
      3'h0: reply_byte = `BLP_REPLY_START;
      3'h1: reply_byte = 8'h00;
      3'h2: reply_byte = `BLP_REPLY_LEN;
      3'h3: reply_byte = resp;
      3'h4: reply_byte = sts;
      3'h5: reply_byte = 8'(8'h00 - (`BLP_REPLY_LEN + resp + sts));
      default: reply_byte = `BLP_PACKET_END;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  blp_state_t state, next_state;
  logic mode_meta, mode_sync;
  logic [1:0] init_cnt, cnt_u, cnt_b, next_cnt_u, next_cnt_b;
  logic [15:0] len;
  logic [8:0] info_left;
  logic [7:0] code, sum, resp, sts;
  logic sum_ok;
  logic [2:0] idx;

  // ---------------------------------------------------------------
  // Receive selection and decode
  // ---------------------------------------------------------------
  // Only the selected link feeds the parser; the rest is dropped
  wire usb_v = usb_rx.valid & usb_rx_en;
  wire rx_v = (link_sel == blp_link_uart) ? uart_rx.valid :
              (link_sel == blp_link_usb) ? usb_v :
              (link_sel == blp_link_dbg) ? dbg_rx.valid : 1'b0;
  wire [7:0] rx_d = (link_sel == blp_link_uart) ? uart_rx.data :
                    (link_sel == blp_link_usb) ? usb_rx.data : dbg_rx.data;
  wire tx_take = tx_valid & tx_ready;
  wire magic = debug_boot_mode_reg == `BLP_DEBUG_MAGIC;
  wire len_bad = (len < `BLP_LEN_MIN) || (len > `BLP_LEN_MAX);
  wire [7:0] sum_next = 8'(sum + rx_d);
  wire end_bad = rx_d != `BLP_PACKET_END;
  wire [7:0] frame_sts = end_bad ? `BLP_STS_PACKET :
                         !sum_ok ? `BLP_STS_CHECKSUM :
                         !cmd_defined(code) ? `BLP_STS_UNSUPPORTED :
                         !cmd_len_ok(code, len) ? `BLP_STS_PACKET : `BLP_STS_OK;
  wire zeros_done = (next_cnt_u == `BLP_ZERO_COUNT) || (next_cnt_b == `BLP_ZERO_COUNT);

  // Zero counters: a byte on one link clears the other's count
  assign next_cnt_u = !uart_rx.valid ? (usb_v ? 2'h0 : cnt_u) :
                      (usb_v || uart_rx.data != 8'h00) ? 2'h0 : 2'(cnt_u + 2'h1);
  assign next_cnt_b = !usb_v ? (uart_rx.valid ? 2'h0 : cnt_b) :
                      (uart_rx.valid || usb_rx.data != 8'h00) ? 2'h0 : 2'(cnt_b + 2'h1);

  // Transmit side is a decode of registered state only
  assign tx_valid = (state == blp_st_ack) || (state == blp_st_boot) || (state == blp_st_reply);
  assign tx_data = (state == blp_st_ack) ? `BLP_ACK_BYTE :
                   (state == blp_st_boot) ? `BLP_BOOT_CODE : reply_byte(idx, resp, sts);
  assign link_up = state >= blp_st_hunt;
  assign uart_tx_pullup_en = (state != blp_st_init) && (state != blp_st_halt);
  assign usb_enum_en = (state == blp_st_zeros) || (link_sel == blp_link_usb);
  assign usb_rx_en = usb_enum_en & usb_configured;

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      blp_st_init: if (init_cnt == `BLP_SYNC_WAIT) next_state = blp_st_decide;
      blp_st_decide: begin
        if (!mode_sync) next_state = blp_st_halt;
        else if (magic) next_state = blp_st_wait_gen;
        else if (!flash_head_erased) next_state = blp_st_halt;
        else next_state = blp_st_zeros;
      end
      blp_st_halt: next_state = blp_st_halt;
      blp_st_zeros: if (zeros_done) next_state = blp_st_ack;
      blp_st_ack: if (tx_take) next_state = blp_st_wait_gen;
      blp_st_wait_gen: if (rx_v && rx_d == `BLP_GENERIC_CODE) next_state = blp_st_boot;
      blp_st_boot: if (tx_take) next_state = blp_st_drain;
      blp_st_drain: if (tx_idle) next_state = blp_st_hunt;
      blp_st_hunt: if (rx_v && rx_d == `BLP_CMD_START) next_state = blp_st_len_hi;
      blp_st_len_hi: if (rx_v) next_state = blp_st_len_lo;
      blp_st_len_lo: if (rx_v) next_state = blp_st_code;
      blp_st_code: begin
        if (len_bad) next_state = blp_st_reply;
        else if (rx_v) next_state = (len == `BLP_LEN_MIN) ? blp_st_sum : blp_st_info;
      end
      blp_st_info: if (rx_v && info_left == 9'h001) next_state = blp_st_sum;
      blp_st_sum: if (rx_v) next_state = blp_st_end;
      blp_st_end: if (rx_v) next_state = (frame_sts == `BLP_STS_OK) ? blp_st_hunt : blp_st_reply;
      blp_st_reply: if (tx_take && idx == `BLP_REPLY_LAST) next_state = blp_st_hunt;
    endcase
  end

  // ---------------------------------------------------------------
  // Sequencing registers
  // ---------------------------------------------------------------
  // Boot pin is asynchronous, so it is caught only through two flops
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode_meta <= 1'b0;
      mode_sync <= 1'b0;
      state <= blp_st_init;
      init_cnt <= 2'h0;
      cnt_u <= 2'h0;
      cnt_b <= 2'h0;
      link_sel <= blp_link_none;
      sw_reset_req <= 1'b0;
      uart_tx_drive_high <= 1'b0;
      uart_baud_div <= `BLP_UART_DIV;
    end else begin
      mode_meta <= boot_mode_pin;
      mode_sync <= mode_meta;
      state <= next_state;
      init_cnt <= (init_cnt == `BLP_SYNC_WAIT) ? init_cnt : 2'(init_cnt + 2'h1);
      cnt_u <= (state == blp_st_zeros) ? next_cnt_u : 2'h0;
      cnt_b <= (state == blp_st_zeros) ? next_cnt_b : 2'h0;
      sw_reset_req <= (state == blp_st_decide) && mode_sync && !magic && !flash_head_erased;
      uart_baud_div <= `BLP_UART_DIV;
      // Link is chosen once and then held until reset
      if (state == blp_st_decide && mode_sync && magic) begin
        link_sel <= blp_link_dbg;
      end else if (state == blp_st_zeros && zeros_done) begin
        link_sel <= (next_cnt_u == `BLP_ZERO_COUNT) ? blp_link_uart : blp_link_usb;
        uart_tx_drive_high <= next_cnt_u == `BLP_ZERO_COUNT;
      end
    end
  end

  // ---------------------------------------------------------------
  // Packet datapath
  // ---------------------------------------------------------------
  // Payload is not stored; the executor sees only code and length
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      len <= 16'h0000;
      info_left <= 9'h000;
      code <= 8'h00;
      sum <= 8'h00;
      sum_ok <= 1'b0;
      resp <= 8'h00;
      sts <= 8'h00;
      idx <= 3'h0;
      cmd_out <= '0;
      err_status <= 8'h00;
      err_pulse <= 1'b0;
    end else begin
      cmd_out.valid <= 1'b0;
      err_pulse <= 1'b0;
      if (tx_take && state == blp_st_reply) idx <= 3'(idx + 3'h1);
      if (state == blp_st_code && len_bad) begin
        resp <= `BLP_RESP_ERROR;
        sts <= `BLP_STS_PACKET;
        err_status <= `BLP_STS_PACKET;
        err_pulse <= 1'b1;
        idx <= 3'h0;
      end else if (rx_v) begin
        unique case (state)
          blp_st_len_hi: begin
            len[15:8] <= rx_d;
            sum <= rx_d;
          end
          blp_st_len_lo: begin
            len[7:0] <= rx_d;
            sum <= sum_next;
          end
          blp_st_code: begin
            code <= rx_d;
            sum <= sum_next;
            info_left <= 9'(len - 16'h0001);
          end
          blp_st_info: begin
            sum <= sum_next;
            info_left <= 9'(info_left - 9'h001);
          end
          blp_st_sum: sum_ok <= sum_next == 8'h00;
          blp_st_end: begin
            if (frame_sts == `BLP_STS_OK) begin
              cmd_out <= '{valid: 1'b1, code: code, length: len};
            end else begin
              resp <= `BLP_RESP_ERROR | code;
              sts <= frame_sts;
              err_status <= frame_sts;
              err_pulse <= 1'b1;
              idx <= 3'h0;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  a_ack_after_zeros:
    assert property (state == blp_st_zeros && zeros_done |=> tx_valid && tx_data == `BLP_ACK_BYTE)
      else $error("No acknowledge after three zero bytes");
  a_zero_clear_both:
    assert property (state == blp_st_zeros && uart_rx.valid && usb_v |=> cnt_u == 2'h0 && cnt_b == 2'h0)
      else $error("Zero count kept across two links");
  a_boot_code_reply:
    assert property (state == blp_st_wait_gen && rx_v && rx_d == `BLP_GENERIC_CODE
                     |=> tx_valid && tx_data == `BLP_BOOT_CODE)
      else $error("Generic code not answered by boot code");
  a_ignore_other_code:
    assert property (state == blp_st_wait_gen && !(rx_v && rx_d == `BLP_GENERIC_CODE) |=> state == blp_st_wait_gen)
      else $error("Left generic-code wait on another byte");
  a_drain_before_cmd:
    assert property (state == blp_st_drain && !tx_idle |=> !link_up)
      else $error("Command phase before boot code sent");
  a_hunt_discard:
    assert property (state == blp_st_hunt && !(rx_v && rx_d == `BLP_CMD_START) |=> state == blp_st_hunt)
      else $error("Hunt left without start byte");
  a_end_byte_error:
    assert property (state == blp_st_end && rx_v && end_bad
                     |=> err_status == `BLP_STS_PACKET && state == blp_st_reply ##0 tx_data == `BLP_REPLY_START)
      else $error("Missing end byte not reported");
  a_debug_select:
    assert property (state == blp_st_decide && mode_sync && magic |=> link_sel == blp_link_dbg ##1 state == blp_st_wait_gen)
      else $error("Debug link not selected");
  a_soft_reset:
    assert property (state == blp_st_decide && mode_sync && !magic && !flash_head_erased
                     |=> sw_reset_req ##1 !sw_reset_req && state == blp_st_halt)
      else $error("Software reset request wrong");
  a_link_locked:
    assert property (link_sel != blp_link_none |=> $stable(link_sel))
      else $error("Selected link changed");
  a_usb_gate:
    assert property (state == blp_st_zeros && !usb_configured && cnt_b == 2'h0 |=> cnt_b == 2'h0)
      else $error("USB byte counted before configured");

endmodule

`default_nettype wire

// file: sim/blp_host_model.sv
`timescale 1ns/1ns
`default_nettype none

module blp_host_model
  import blp_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic slow,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output var blp_byte_t uart_rx,
  output var blp_byte_t usb_rx,
  output var blp_byte_t dbg_rx,
  output logic tx_ready,
  output logic tx_idle
);
  logic [2:0] busy;
  logic [7:0] got[$];

  // ----------------------------------------
  // Host byte source
  // ----------------------------------------
  initial begin
    uart_rx = '0;
    usb_rx = '0;
    dbg_rx = '0;
  end

  // One byte on one link, valid for a single sampling edge
  task automatic send_byte(input logic [1:0] link, input logic [7:0] b);
    @(posedge mclk);
    if (link == 2'h0) uart_rx <= '{1'b1, b};
    else if (link == 2'h1) usb_rx <= '{1'b1, b};
    else dbg_rx <= '{1'b1, b};
    @(posedge mclk);
    // Idle lines show the inverse so stale data never looks fresh
    uart_rx <= '{1'b0, ~b};
    usb_rx <= '{1'b0, ~b};
    dbg_rx <= '{1'b0, ~b};
  endtask

  // ----------------------------------------
  // Transmit sink
  // ----------------------------------------
  // Slow mode stalls every other cycle; each byte keeps the line busy
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_ready <= 1'b0;
      busy <= 3'h0;
    end else begin
      tx_ready <= slow ? ~tx_ready : 1'b1;
      if (tx_valid && tx_ready) begin
        got.push_back(tx_data);
        busy <= 3'h4;
      end else if (busy != 3'h0) begin
        busy <= busy - 3'h1;
      end
    end
  end

  assign tx_idle = (busy == 3'h0);
endmodule

`default_nettype wire

// file: sim/blp_parser_tb.sv
`timescale 1ns/1ns
`default_nettype none

module blp_parser_tb
  import blp_pkg::*;
;
  logic mclk, rst, boot_mode_pin, flash_head_erased, usb_configured, slow;
  logic [7:0] debug_boot_mode_reg, tx_data, err_status;
  blp_byte_t uart_rx, usb_rx, dbg_rx;
  logic tx_ready, tx_idle, tx_valid, sw_reset_req, uart_tx_pullup_en;
  logic uart_tx_drive_high, usb_enum_en, usb_rx_en, link_up, err_pulse;
  logic [15:0] uart_baud_div;
  blp_link_t link_sel;
  blp_cmd_t cmd_out, last_cmd;
  int fails, check_count, cmd_seen, err_seen, rst_seen;

  blp_parser dut (
    .mclk(mclk), .rst(rst), .boot_mode_pin(boot_mode_pin), .debug_boot_mode_reg(debug_boot_mode_reg),
    .flash_head_erased(flash_head_erased), .usb_configured(usb_configured), .uart_rx(uart_rx),
    .usb_rx(usb_rx), .dbg_rx(dbg_rx), .tx_ready(tx_ready), .tx_idle(tx_idle), .sw_reset_req(sw_reset_req),
    .uart_tx_pullup_en(uart_tx_pullup_en), .uart_tx_drive_high(uart_tx_drive_high),
    .uart_baud_div(uart_baud_div), .usb_enum_en(usb_enum_en), .usb_rx_en(usb_rx_en), .link_sel(link_sel),
    .link_up(link_up), .tx_valid(tx_valid), .tx_data(tx_data), .cmd_out(cmd_out), .err_status(err_status),
    .err_pulse(err_pulse)
  );
  blp_host_model host (
    .mclk(mclk), .rst(rst), .slow(slow), .tx_valid(tx_valid), .tx_data(tx_data), .uart_rx(uart_rx),
    .usb_rx(usb_rx), .dbg_rx(dbg_rx), .tx_ready(tx_ready), .tx_idle(tx_idle)
  );

  // ----------------------------------------
  // Clock and event counters
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // Pulses last one cycle, so count them at every edge
  always @(posedge mclk) begin
    if (cmd_out.valid === 1'b1) begin
      cmd_seen++;
      last_cmd = cmd_out;
    end
    if (err_pulse === 1'b1) err_seen++;
    if (sw_reset_req === 1'b1) rst_seen++;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check16(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check1(input logic got, input logic exp);
    check8({7'h0, got}, {7'h0, exp});
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic tick;
    @(posedge mclk);
    #1;
  endtask

  // Straps are only sampled after release, so set them under reset
  task automatic start(input logic md, input logic [7:0] magic, input logic erased, input logic cfg);
    @(posedge mclk);
    rst <= 1'b1;
    boot_mode_pin <= md;
    debug_boot_mode_reg <= magic;
    flash_head_erased <= erased;
    usb_configured <= cfg;
    slow <= 1'b0;
    repeat (5) @(posedge mclk);
    rst_seen = 0;
    rst <= 1'b0;
    repeat (6) tick();
    host.got.delete();
  endtask

  task automatic wait_tx(input int n);
    for (int k = 0; k < 300 && host.got.size() < n; k++) tick();
    check8(8'(host.got.size()), 8'(n));
  endtask

  task automatic wait_up;
    for (int k = 0; k < 40 && link_up !== 1'b1; k++) tick();
    check1(link_up, 1'b1);
  endtask

  // Bad lengths stop after the low length byte, as the parser does
  task automatic send_pkt(input logic [7:0] code, input logic [15:0] len, input logic [7:0] bad,
                          input logic [7:0] tail);
    logic [7:0] s;
    s = len[15:8] + len[7:0];
    host.send_byte(2'h2, 8'h01);
    host.send_byte(2'h2, len[15:8]);
    host.send_byte(2'h2, len[7:0]);
    if (len == 16'h0 || len > 16'h0100) return;
    host.send_byte(2'h2, code);
    s = s + code;
    for (int i = 1; i < len; i++) begin
      host.send_byte(2'h2, 8'h20 + 8'(i));
      s = s + 8'h20 + 8'(i);
    end
    host.send_byte(2'h2, (8'h0 - s) ^ bad);
    host.send_byte(2'h2, tail);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_uart;
    start(1'b1, 8'h00, 1'b1, 1'b1);
    check1(uart_tx_pullup_en, 1'b1);
    check1(uart_tx_drive_high, 1'b0);
    check16(uart_baud_div, 16'h1458);
    host.send_byte(2'h0, 8'h00);
    host.send_byte(2'h0, 8'h07);
    host.send_byte(2'h0, 8'h00);
    host.send_byte(2'h0, 8'h00);
    host.send_byte(2'h1, 8'h00);
    host.send_byte(2'h0, 8'h00);
    host.send_byte(2'h0, 8'h00);
    repeat (3) tick();
    check8(8'(host.got.size()), 8'h00);
    // Host keeps sending zeros until the acknowledge shows up
    for (int k = 0; k < 4 && host.got.size() == 0; k++) host.send_byte(2'h0, 8'h00);
    wait_tx(1);
    check8(host.got[0], 8'h00);
    check8(8'(link_sel), 8'(blp_link_uart));
    check1(uart_tx_drive_high, 1'b1);
    check1(usb_rx_en, 1'b0);
    host.send_byte(2'h0, 8'h11);
    host.send_byte(2'h1, 8'h55);
    repeat (3) tick();
    check8(8'(host.got.size()), 8'h01);
    host.send_byte(2'h0, 8'h55);
    wait_tx(2);
    check8(host.got[1], 8'hc6);
    check1(link_up, 1'b0);
    wait_up();
  endtask

  task automatic t_usb;
    start(1'b1, 8'h00, 1'b1, 1'b0);
    check1(usb_enum_en, 1'b1);
    check1(usb_rx_en, 1'b0);
    repeat (3) host.send_byte(2'h1, 8'h00);
    repeat (3) tick();
    check8(8'(host.got.size()), 8'h00);
    @(posedge mclk);
    usb_configured <= 1'b1;
    repeat (3) host.send_byte(2'h1, 8'h00);
    wait_tx(1);
    check8(8'(link_sel), 8'(blp_link_usb));
    check1(usb_rx_en, 1'b1);
    check1(uart_tx_drive_high, 1'b0);
    host.send_byte(2'h1, 8'h55);
    wait_tx(2);
    check8(host.got[1], 8'hc6);
    wait_up();
  endtask

  task automatic t_err(input logic [7:0] code, input logic [15:0] len, input logic [7:0] bad,
                       input logic [7:0] tail, input logic [7:0] sts);
    logic [7:0] resp;
    int e;
    resp = (len == 16'h0 || len > 16'h0100) ? 8'h80 : (8'h80 | code);
    e = err_seen;
    host.got.delete();
    send_pkt(code, len, bad, tail);
    wait_tx(7);
    check8(err_status, sts);
    check8(8'(err_seen - e), 8'h01);
    check8(host.got[0], 8'h81);
    check8(host.got[1], 8'h00);
    check8(host.got[2], 8'h02);
    check8(host.got[3], resp);
    check8(host.got[4], sts);
    check8(host.got[5], 8'h0 - 8'h02 - resp - sts);
    check8(host.got[6], 8'h03);
  endtask

  task automatic t_dbg;
    start(1'b1, 8'ha5, 1'b1, 1'b1);
    @(posedge mclk);
    slow <= 1'b1;
    host.send_byte(2'h2, 8'h55);
    wait_tx(1);
    check8(host.got[0], 8'hc6);
    check8(8'(link_sel), 8'(blp_link_dbg));
    wait_up();
    host.send_byte(2'h2, 8'h77);
    send_pkt(8'h00, 16'h0001, 8'h00, 8'h03);
    repeat (3) tick();
    check8(8'(cmd_seen), 8'h01);
    check8(last_cmd.code, 8'h00);
    check16(last_cmd.length, 16'h0001);
    t_err(8'h00, 16'h0001, 8'h00, 8'h04, 8'hc1);
    t_err(8'h00, 16'h0001, 8'h01, 8'h03, 8'hc2);
    t_err(8'hff, 16'h0001, 8'h00, 8'h03, 8'hc0);
    t_err(8'h00, 16'h0002, 8'h00, 8'h03, 8'hc1);
    t_err(8'h00, 16'h0000, 8'h00, 8'h03, 8'hc1);
    t_err(8'h00, 16'h0101, 8'h00, 8'h03, 8'hc1);
    send_pkt(8'h00, 16'h0001, 8'h00, 8'h03);
    repeat (3) tick();
    check8(8'(cmd_seen), 8'h02);
  endtask

  task automatic t_sw;
    start(1'b1, 8'h00, 1'b0, 1'b0);
    repeat (8) tick();
    check8(8'(rst_seen), 8'h01);
    check8(8'(link_sel), 8'(blp_link_none));
    // Pin low: magic alone must not open the debug link, and no soft reset
    start(1'b0, 8'ha5, 1'b0, 1'b0);
    repeat (8) tick();
    check8(8'(rst_seen), 8'h00);
    check8(8'(link_sel), 8'(blp_link_none));
    check1(uart_tx_pullup_en, 1'b0);
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    boot_mode_pin = 1'b0;
    debug_boot_mode_reg = 8'h00;
    flash_head_erased = 1'b1;
    usb_configured = 1'b0;
    slow = 1'b0;
    t_uart();
    t_usb();
    t_dbg();
    t_sw();
    stop_test();
  end

  // Whole run needs a few hundred cycles; this bound allows ample margin
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    stop_test();
  end
endmodule

`default_nettype wire
